//--- design/spm_pkg.sv
package spm_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int SPM_SAMPLE_W = 14;
    localparam int SPM_PEAK_W = 13;
    localparam int SPM_WIN_W = 24;
    localparam int SPM_CS_W = 3;
    localparam int SPM_ADDR_W = 15;
    localparam int SPM_DATA_W = 8;
    localparam int SPM_FRAME_W = 25;
    localparam int SPM_SUB_W = 5;
    localparam int SPM_SUBS = 5;
    localparam int SPM_SPI_BITS = 24;
    localparam int SPM_SPI_HDR = 16;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [14:0] SPM_CTRL_ADDR = 15'h0270;
    localparam logic [14:0] SPM_WIN0_ADDR = 15'h0271;
    localparam logic [14:0] SPM_WIN1_ADDR = 15'h0272;
    localparam logic [14:0] SPM_WIN2_ADDR = 15'h0273;
    localparam logic [14:0] SPM_PEAK0_ADDR = 15'h0274;
    localparam logic [14:0] SPM_PEAK1_ADDR = 15'h0275;
    localparam logic [14:0] SPM_SERA_ADDR = 15'h0279;
    localparam logic [14:0] SPM_SERB_ADDR = 15'h027A;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int SPM_CTRL_PEAK_BIT = 1;
    localparam int SPM_SERB_EN_BIT = 1;
    localparam logic [1:0] SPM_SERA_EN_VAL = 2'h3;
    localparam logic [7:0] SPM_BYTE_RST = 8'h00;
    localparam logic [23:0] SPM_WIN_RST = 24'h000100;
    localparam logic [12:0] SPM_PEAK_RST = 13'h0000;
    localparam logic [12:0] SPM_MAG_MAX = 13'h1FFF;

endpackage

//--- design/spm_spi_slave.sv
`timescale 1ns/1ns
module spm_spi_slave (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // conditioned pin events
    input wire logic sclk_rise_in,
    input wire logic sclk_fall_in,
    input wire logic select_in,
    input wire logic sdi_in,
    // register side
    input wire logic [spm_pkg::SPM_DATA_W-1:0] rd_data_in,
    output logic [spm_pkg::SPM_ADDR_W-1:0] addr_out,
    output logic [spm_pkg::SPM_DATA_W-1:0] wr_data_out,
    output logic wr_strobe_out,
    output logic sdo_out,
    output logic sdo_drive_out
);
    import spm_pkg::*;

    logic [23:0] shift_reg;
    logic [4:0] count_reg;
    logic [7:0] out_reg;
    logic load_reg;
    logic read_reg;
    logic is_read;

    // read flag held from end of header until deselect
    assign is_read = read_reg;
    // address sits low until the data bits push it up
    assign addr_out = count_reg == 5'd24 ? shift_reg[22:8] : shift_reg[14:0];
    assign wr_data_out = shift_reg[7:0];
    assign sdo_drive_out = is_read && select_in;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !select_in) begin
            count_reg <= 5'd0;
            shift_reg <= 24'h000000;
            load_reg <= 1'b0;
            read_reg <= 1'b0;
            wr_strobe_out <= 1'b0;
        end else begin
            load_reg <= sclk_rise_in && count_reg == 5'd15;
            read_reg <= read_reg || (sclk_rise_in && count_reg == 5'd15 && shift_reg[14]);
            wr_strobe_out <= sclk_rise_in && count_reg == 5'd23 && !shift_reg[22];
            if (sclk_rise_in && count_reg != 5'd24) begin
                shift_reg <= {shift_reg[22:0], sdi_in};
                count_reg <= count_reg + 5'd1;
            end
        end
    end

    // read data shifted out msb first on falling edges
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            out_reg <= SPM_BYTE_RST;
            sdo_out <= 1'b0;
        end else if (load_reg) begin
            out_reg <= rd_data_in;
        end else if (sclk_fall_in && is_read) begin
            sdo_out <= out_reg[7];
            out_reg <= {out_reg[6:0], 1'b0};
        end
    end
endmodule

//--- design/spm_frame_tx.sv
`timescale 1ns/1ns
module spm_frame_tx (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // control
    input wire logic enable_in,
    input wire logic sample_en_in,
    input wire logic load_in,
    input wire logic [spm_pkg::SPM_PEAK_W-1:0] peak_in,
    // serial control bit
    output logic bit_out
);
    import spm_pkg::*;

    logic [SPM_FRAME_W-1:0] frame_word;
    logic [SPM_FRAME_W-1:0] shift_reg;
    logic [4:0] left_reg;
    logic [SPM_PEAK_W-1:0] pend_reg;
    logic pend_reg_v;
    logic [19:0] payload;

    assign payload = {7'h00, pend_reg};

    // five subframes, each a start bit then four data bits
    genvar s;
    generate
        for (s = 0; s < SPM_SUBS; s++) begin : g_sub
            assign frame_word[SPM_FRAME_W-1-s*SPM_SUB_W -: SPM_SUB_W] =
                {1'b1, payload[19-s*4 -: 4]}; // R17
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !enable_in) begin
            pend_reg <= SPM_PEAK_RST;
            pend_reg_v <= 1'b0;
        end else if (load_in) begin
            pend_reg <= peak_in;
            pend_reg_v <= 1'b1;
        end else if (sample_en_in && left_reg == 5'd0) begin
            pend_reg_v <= 1'b0;
        end
    end

    // one bit per sample, msb first
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || !enable_in) begin
            shift_reg <= '0;
            left_reg <= 5'd0;
            bit_out <= 1'b0;
        end else if (sample_en_in) begin
            if (left_reg != 5'd0) begin
                bit_out <= shift_reg[SPM_FRAME_W-1]; // R16
                shift_reg <= {shift_reg[SPM_FRAME_W-2:0], 1'b0};
                left_reg <= left_reg - 5'd1;
            end else if (pend_reg_v && !load_in) begin
                bit_out <= frame_word[SPM_FRAME_W-1];
                shift_reg <= {frame_word[SPM_FRAME_W-2:0], 1'b0};
                left_reg <= 5'(SPM_FRAME_W - 1);
            end else begin
                bit_out <= 1'b0;
            end
        end
    end
endmodule

//--- design/spm_top.sv
// What this block does
// R1 - keep largest sample magnitude in window
// R2 - 13-bit peak, 24-bit window length
// R3 - detection runs while control bit 1 set
// R4 - software writes window length before enabling
// R5 - enable loads window into sample down-counter
// R6 - compare magnitude with hidden stored peak
// R7 - stored peak starts at current sample magnitude
// R8 - counter at 1 copies peak to holding
// R9 - counter reloads, windows repeat continuously
// R10 - first sample of window overwrites stored peak
// R11 - results by register readback or stream
// R12 - stream enabled by two serial enable registers
// R13 - three control bits, monitor uses one
// R14 - monitor bit sits in top control position
// R15 - software routes serial output into control bits
// R16 - 25-bit frame, msb first, five subframes
// R17 - each subframe opens with a start bit
// R18 - holding keeps value until next expiry
// R19 - magnitude is absolute value, 13 bits
`timescale 1ns/1ns
module spm_top (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,

    // decimated samples
    input wire logic [spm_pkg::SPM_SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_in,

    // serial control port pins
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe_n_out,

    // control bits toward the link
    output logic [spm_pkg::SPM_CS_W-1:0] ctrl_bits_out,
    output logic ctrl_valid_out,

    // monitor status
    output logic [spm_pkg::SPM_PEAK_W-1:0] peak_out,
    output logic peak_update_out
);
    import spm_pkg::*;

    // ----------------------------------------------------------------
    // pin conditioning
    // ----------------------------------------------------------------
    logic [2:0] pin_vec;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic [2:0] pin_reg;
    logic [2:0] pin_next;
    logic [2:0] agree;

    assign pin_vec = {spi_sclk_in, spi_cs_n_in, spi_sdio_in};
    assign agree = ~(sync2_reg ^ sync3_reg);
    assign pin_next = (agree & sync2_reg) | (~agree & pin_reg);

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sync1_reg <= 3'h2;
            sync2_reg <= 3'h2;
            sync3_reg <= 3'h2;
        end else begin
            sync1_reg <= pin_vec;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pin_reg <= 3'h2;
        end else begin
            pin_reg <= pin_next;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic spi_select;

    assign sclk_rise = pin_next[2] && !pin_reg[2];
    assign sclk_fall = !pin_next[2] && pin_reg[2];
    assign spi_select = !pin_reg[1];

    // ----------------------------------------------------------------
    // serial control port
    // ----------------------------------------------------------------
    logic [SPM_ADDR_W-1:0] bus_addr;
    logic [SPM_DATA_W-1:0] bus_wdata;
    logic [SPM_DATA_W-1:0] bus_rdata;
    logic bus_write;
    logic sdo_bit;
    logic sdo_drive;

    spm_spi_slave u_spi (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .sclk_rise_in(sclk_rise),
        .sclk_fall_in(sclk_fall),
        .select_in(spi_select),
        .sdi_in(pin_reg[0]),
        .rd_data_in(bus_rdata),
        .addr_out(bus_addr),
        .wr_data_out(bus_wdata),
        .wr_strobe_out(bus_write),
        .sdo_out(sdo_bit),
        .sdo_drive_out(sdo_drive)
    );

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            spi_sdio_out <= 1'b0;
            spi_sdio_oe_n_out <= 1'b1;
        end else begin
            spi_sdio_out <= sdo_bit;
            spi_sdio_oe_n_out <= !sdo_drive;
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [SPM_WIN_W-1:0] win_reg; // R2
    logic [7:0] ser_a_reg;
    logic [7:0] ser_b_reg;
    logic [SPM_PEAK_W-1:0] hold_reg;

    logic sel_ctrl;
    logic sel_win0;
    logic sel_win1;
    logic sel_win2;
    logic sel_peak0;
    logic sel_peak1;
    logic sel_ser_a;
    logic sel_ser_b;

    assign sel_ctrl = bus_addr == SPM_CTRL_ADDR;
    assign sel_win0 = bus_addr == SPM_WIN0_ADDR;
    assign sel_win1 = bus_addr == SPM_WIN1_ADDR;
    assign sel_win2 = bus_addr == SPM_WIN2_ADDR;
    assign sel_peak0 = bus_addr == SPM_PEAK0_ADDR;
    assign sel_peak1 = bus_addr == SPM_PEAK1_ADDR;
    assign sel_ser_a = bus_addr == SPM_SERA_ADDR;
    assign sel_ser_b = bus_addr == SPM_SERB_ADDR;

    // unmapped addresses read as zero
    assign bus_rdata =
        sel_ctrl ? ctrl_reg :
        sel_win0 ? win_reg[7:0] :
        sel_win1 ? win_reg[15:8] :
        sel_win2 ? win_reg[23:16] :
        sel_peak0 ? hold_reg[7:0] : // R11
        sel_peak1 ? {3'h0, hold_reg[12:8]} :
        sel_ser_a ? ser_a_reg :
        sel_ser_b ? ser_b_reg :
        SPM_BYTE_RST;

    logic wr_ctrl;
    logic wr_ser_a;
    logic wr_ser_b;

    assign wr_ctrl = bus_write && sel_ctrl;
    assign wr_ser_a = bus_write && sel_ser_a;
    assign wr_ser_b = bus_write && sel_ser_b;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ctrl_reg <= SPM_BYTE_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= bus_wdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ser_a_reg <= SPM_BYTE_RST;
        end else if (wr_ser_a) begin
            ser_a_reg <= bus_wdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ser_b_reg <= SPM_BYTE_RST;
        end else if (wr_ser_b) begin
            ser_b_reg <= bus_wdata;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            win_reg <= SPM_WIN_RST;
        end else if (bus_write) begin
            if (sel_win0) begin
                win_reg[7:0] <= bus_wdata;
            end
            if (sel_win1) begin
                win_reg[15:8] <= bus_wdata;
            end
            if (sel_win2) begin
                win_reg[23:16] <= bus_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // sample magnitude
    // ----------------------------------------------------------------
    logic [SPM_SAMPLE_W-1:0] abs_full;
    logic [SPM_PEAK_W-1:0] mag;

    assign abs_full = sample_in[SPM_SAMPLE_W-1] ? (~sample_in + 14'h0001) : sample_in; // R19
    assign mag = abs_full[SPM_SAMPLE_W-1] ? SPM_MAG_MAX : abs_full[SPM_PEAK_W-1:0]; // R19

    // ----------------------------------------------------------------
    // peak detector
    // ----------------------------------------------------------------
    logic peak_en;
    logic run_reg;
    logic start;
    logic first_reg;
    logic first_next;
    logic [SPM_WIN_W-1:0] cnt_reg;
    logic [SPM_WIN_W-1:0] cnt_next;
    logic [SPM_PEAK_W-1:0] stored_reg;
    logic [SPM_PEAK_W-1:0] stored_next;
    logic [SPM_PEAK_W-1:0] cand;
    logic expire;
    logic step;

    assign peak_en = ctrl_reg[SPM_CTRL_PEAK_BIT]; // R3
    assign start = peak_en && !run_reg;
    assign step = peak_en && run_reg && sample_valid_in;
    assign expire = step && cnt_reg <= 24'h000001; // R8

    // first sample seeds, later ones keep the greater
    assign cand = first_reg ? mag : // R7 R10
        (mag > stored_reg ? mag : stored_reg); // R1 R6

    assign stored_next = step ? cand : stored_reg;

    assign cnt_next =
        start ? win_reg : // R4 R5
        expire ? win_reg : // R9
        step ? cnt_reg - 24'h000001 : // R5
        cnt_reg;

    assign first_next =
        start ? 1'b1 :
        expire ? 1'b1 : // R10
        step ? 1'b0 :
        first_reg;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            run_reg <= 1'b0;
        end else begin
            run_reg <= peak_en;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cnt_reg <= SPM_WIN_RST;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            first_reg <= 1'b1;
        end else begin
            first_reg <= first_next;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            stored_reg <= SPM_PEAK_RST;
        end else begin
            stored_reg <= stored_next;
        end
    end

    // holding register changes only on expiry
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            hold_reg <= SPM_PEAK_RST;
        end else if (expire) begin
            hold_reg <= cand; // R8 R18
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            peak_out <= SPM_PEAK_RST;
        end else if (expire) begin
            peak_out <= cand; // R18
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            peak_update_out <= 1'b0;
        end else begin
            peak_update_out <= expire;
        end
    end

    // ----------------------------------------------------------------
    // monitor stream over control bits
    // ----------------------------------------------------------------
    logic stream_en;
    logic tx_bit;

    assign stream_en = ser_a_reg[1:0] == SPM_SERA_EN_VAL &&
        ser_b_reg[SPM_SERB_EN_BIT]; // R12

    spm_frame_tx u_tx (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .enable_in(stream_en),
        .sample_en_in(sample_valid_in),
        .load_in(expire),
        .peak_in(cand),
        .bit_out(tx_bit)
    );

    // single monitor bit in the top control position
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ctrl_bits_out <= '0;
            ctrl_valid_out <= 1'b0;
        end else begin
            ctrl_bits_out <= {tx_bit, 2'h0}; // R13 R14
            ctrl_valid_out <= sample_valid_in;
        end
    end

endmodule

//--- sim/spm_top_assertions.sv
`timescale 1ns/1ns
module spm_top_checker (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // watched ports
    input wire logic [spm_pkg::SPM_SAMPLE_W-1:0] sample_in,
    input wire logic sample_valid_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sdio_oe_n_out,
    input wire logic [spm_pkg::SPM_CS_W-1:0] ctrl_bits_out,
    input wire logic ctrl_valid_out,
    input wire logic [spm_pkg::SPM_PEAK_W-1:0] peak_out,
    input wire logic peak_update_out
);
    import spm_pkg::*;
    // ------------
    // window model
    // ------------
    logic [13:0] neg;
    logic [12:0] mag;
    logic [12:0] mx_reg;
    logic [12:0] mx_next;
    logic prev_reg;
    logic seen_reg;
    assign neg = ~sample_in + 14'h0001;
    assign mag = sample_in[13] ? (neg[13] ? SPM_MAG_MAX : neg[12:0]) : sample_in[12:0];
    assign mx_next = peak_update_out ? (sample_valid_in ? mag : 13'h0000)
        : (sample_valid_in && mag > mx_reg) ? mag : mx_reg;
    // register accesses may retune the window, so the next one is not judged
    always_ff @(posedge ref_clk_in) begin
        mx_reg <= reset_in ? 13'h0000 : mx_next;
        prev_reg <= !reset_in && spi_cs_n_in && (prev_reg || peak_update_out);
        seen_reg <= !reset_in && (seen_reg || !spi_cs_n_in);
    end
    // ------------
    // assertions
    // ------------
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);
    a_peak_is_max: assert property (peak_update_out && prev_reg |-> peak_out == mx_reg)
        else $error("peak differs from window maximum");
    a_update_cause: assert property (peak_update_out |-> $past(sample_valid_in))
        else $error("window expired without a sample");
    a_update_access: assert property (peak_update_out |-> seen_reg)
        else $error("detection ran before being enabled");
    a_peak_hold: assert property (!peak_update_out |-> $stable(peak_out))
        else $error("peak changed between expiries");
    a_ctrl_low_zero: assert property (ctrl_bits_out[1:0] == 2'h0)
        else $error("monitor bit outside top control position");
    a_valid_follow: assert property (sample_valid_in |=> ctrl_valid_out)
        else $error("control bits missed a sample");
    a_valid_quiet: assert property (!sample_valid_in |=> !ctrl_valid_out)
        else $error("control bits without a sample");
    a_oe_idle: assert property (spi_cs_n_in [*8] |-> spi_sdio_oe_n_out)
        else $error("serial data driven while deselected");
endmodule
bind spm_top spm_top_checker i_spm_top_checker (.ref_clk_in, .reset_in, .sample_in,
    .sample_valid_in, .spi_cs_n_in, .spi_sdio_oe_n_out, .ctrl_bits_out, .ctrl_valid_out,
    .peak_out, .peak_update_out);

//--- sim/spm_link_rx_model.sv
`timescale 1ns/1ns
module spm_link_rx_model (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_in,
    // control bits of each sample
    input wire logic [spm_pkg::SPM_CS_W-1:0] ctrl_bits_in,
    input wire logic ctrl_valid_in,
    // recovered monitor word
    output logic [spm_pkg::SPM_PEAK_W-1:0] rx_peak_out,
    output logic [7:0] rx_frames_out,
    output logic rx_bad_out
);
    import spm_pkg::*;
    logic [24:0] word;
    logic [23:0] sh_reg;
    logic [4:0] cnt_reg;
    assign word = {sh_reg, ctrl_bits_in[2]};
    always @(posedge ref_clk_in) begin
        if (reset_in) begin
            cnt_reg <= 5'h00;
            rx_frames_out <= 8'h00;
            rx_bad_out <= 1'b0;
            rx_peak_out <= 13'h0000;
        end else if (ctrl_valid_in) begin
            sh_reg <= word[23:0];
            if (cnt_reg == 5'h00) begin
                cnt_reg <= {4'h0, ctrl_bits_in[2]};
            end else if (cnt_reg != 5'h18) begin
                cnt_reg <= cnt_reg + 5'h01;
            end else begin
                cnt_reg <= 5'h00;
                rx_frames_out <= rx_frames_out + 8'h01;
                rx_peak_out <= {word[15], word[13:10], word[8:5], word[3:0]};
                rx_bad_out <= rx_bad_out || {word[24], word[19], word[14], word[9], word[4]}
                    != 5'h1F || {word[23:20], word[18:16]} != 7'h00;
            end
        end
    end
endmodule

//--- sim/spm_top_tb_top.sv
`timescale 1ns/1ns
module spm_top_tb_top;
    import spm_pkg::*;
    logic clk, rst, smp_v, sclk, cs_n, sdi, sdo, oe_n, sdio_w, cval, pupd, rx_bad;
    logic [13:0] smp_d;
    logic [2:0] cbits;
    logic [12:0] peak, rx_peak;
    logic [7:0] rx_frames;
    int bad_count, checks_done, upd_cnt;
    `define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
        $display("BAD %s exp %0h got %0h", n, e, g); end end
    assign sdio_w = oe_n ? sdi : sdo;
    spm_top i_spm_top (.ref_clk_in(clk), .reset_in(rst), .sample_in(smp_d),
        .sample_valid_in(smp_v), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_sdio_in(sdio_w),
        .spi_sdio_out(sdo), .spi_sdio_oe_n_out(oe_n), .ctrl_bits_out(cbits),
        .ctrl_valid_out(cval), .peak_out(peak), .peak_update_out(pupd));
    spm_link_rx_model i_spm_link_rx_model (.ref_clk_in(clk), .reset_in(rst),
        .ctrl_bits_in(cbits), .ctrl_valid_in(cval), .rx_peak_out(rx_peak),
        .rx_frames_out(rx_frames), .rx_bad_out(rx_bad));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (pupd === 1'b1) upd_cnt++;
    // ------------
    // bus cycles
    // ------------
    task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd,
        output logic [7:0] rv);
        logic [23:0] f;
        f = {rd, a, wd};
        rv = 8'h00;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi <= f[i];
            repeat (8) @(posedge clk);
            if (i < 8) rv[i] = sdio_w;
            sclk <= 1'b1;
            repeat (8) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (12) @(posedge clk);
        cs_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi(1'b0, a, d, x);
    endtask
    task automatic smp(input logic [13:0] s);
        @(posedge clk) smp_v <= 1'b1;
        smp_d <= s;
        @(posedge clk) smp_v <= 1'b0;
    endtask
    // ------------
    // scenarios
    // ------------
    task automatic t_reset;
        logic [14:0] a [9];
        logic [7:0] e [9];
        logic [7:0] v;
        a = '{SPM_CTRL_ADDR, SPM_WIN0_ADDR, SPM_WIN1_ADDR, SPM_WIN2_ADDR, SPM_PEAK0_ADDR,
            SPM_PEAK1_ADDR, SPM_SERA_ADDR, SPM_SERB_ADDR, 15'h0300};
        e = '{SPM_BYTE_RST, SPM_WIN_RST[7:0], SPM_WIN_RST[15:8], SPM_WIN_RST[23:16],
            8'h00, 8'h00, SPM_BYTE_RST, SPM_BYTE_RST, 8'h00};
        for (int i = 0; i < 9; i++) begin
            spi(1'b1, a[i], 8'h00, v);
            `CHK("reg reset", e[i], v)
        end
        $display("reset test done");
    endtask
    task automatic t_window;
        logic [13:0] s [12];
        logic [12:0] e [3];
        s = '{14'h0064, 14'h3ED4, 14'h0032, 14'h0007, 14'h3FFB, 14'h0003, 14'h0002,
            14'h0001, 14'h2000, 14'h0000, 14'h0000, 14'h0000};
        e = '{13'h012C, 13'h0005, 13'h1FFF};
        wr(SPM_WIN0_ADDR, 8'h04);
        wr(SPM_WIN1_ADDR, 8'h00);
        wr(SPM_CTRL_ADDR, 8'h02);
        upd_cnt = 0;
        for (int w = 0; w < 3; w++) begin
            for (int k = 0; k < 4; k++) begin
                smp(s[w * 4 + k]);
                if (k == 2) begin
                    repeat (4) @(negedge clk);
                    `CHK("early expiry", w, upd_cnt)
                end
            end
            repeat (4) @(negedge clk);
            `CHK("expiries", w + 1, upd_cnt)
            `CHK("window peak", e[w], peak)
        end
        $display("window test done");
    endtask
    task automatic t_readback;
        logic [7:0] v;
        spi(1'b1, SPM_PEAK0_ADDR, 8'h00, v);
        `CHK("peak low", 8'hFF, v)
        spi(1'b1, SPM_PEAK1_ADDR, 8'h00, v);
        `CHK("peak high", 8'h1F, v)
        wr(SPM_PEAK0_ADDR, 8'h12);
        spi(1'b1, SPM_PEAK0_ADDR, 8'h00, v);
        `CHK("peak kept", 8'hFF, v)
        $display("readback test done");
    endtask
    task automatic t_stream;
        wr(SPM_SERA_ADDR, 8'h03);
        wr(SPM_SERB_ADDR, 8'h02);
        repeat (40) smp(14'h3B2E);
        repeat (4) @(negedge clk);
        `CHK("frame seen", 1'b1, rx_frames != 8'h00)
        `CHK("frame peak", 13'h04D2, rx_peak)
        `CHK("frame shape", 1'b0, rx_bad)
        $display("stream test done");
    endtask
    task automatic t_disable;
        int c;
        wr(SPM_CTRL_ADDR, 8'h00);
        c = upd_cnt;
        repeat (8) smp(14'h0100);
        repeat (4) @(negedge clk);
        `CHK("frozen", c, upd_cnt)
        wr(SPM_CTRL_ADDR, 8'h02);
        repeat (4) smp(14'h3FF9);
        repeat (4) @(negedge clk);
        `CHK("reload", c + 1, upd_cnt)
        `CHK("reload peak", 13'h0007, peak)
        $display("disable test done");
    endtask
    task automatic stop_test;
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        smp_v = 1'b0;
        smp_d = 14'h0000;
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_window;
        t_readback;
        t_stream;
        t_disable;
        stop_test;
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("BAD watchdog exp 0 got 1");
        stop_test;
    end
endmodule
